/* File: rtl/acs_pkg.sv */
// constants, field layouts and carrier types of the conversion sequencer
// assumes a single 20 MHz core clock; all times are turned into cycle counts here
package acs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS     = 50;
  localparam int TEMP_NS    = 53100;
  localparam int TEMP_CYC   = (TEMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_NS  = 4000;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_NS    = 2000;
  localparam int WAKE_CYC   = (WAKE_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // modes and reset values
  localparam logic [1:0] MODE_RST    = 2'h2;
  localparam logic [1:0] MODE_EXT    = 2'h3;
  localparam logic [1:0] SCAN_FROM0  = 2'h0;
  localparam logic [1:0] SCAN_TOLAST = 2'h1;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] SCAN_SINGLE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // serial command layout
  localparam int         CONV_BIT      = 7;
  localparam logic [7:0] NOP_BYTE      = 8'h00;
  localparam logic [1:0] DAC_PREFIX    = 2'h1;
  localparam logic [2:0] GPIO_PREFIX   = 3'h1;
  localparam logic [4:0] BYTE_BITS     = 5'h08;
  localparam logic [4:0] WORD_BITS     = 5'h10;
  localparam logic [3:0] LEAD_ZEROS    = 4'h0;
  localparam logic [4:0] NOP_PD_CNT    = 5'h02;
  localparam logic [4:0] TEMP_LOAD_CNT = 5'h16;
  localparam logic [4:0] TEMP_END_CNT  = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [3:0] chsel;
    logic [1:0] scan;
    logic       temp;
  } acs_conv_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  ch;
    logic [11:0] data;
  } acs_dac_wr_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_WAKE   = 5'b00010,
    ST_TEMP   = 5'b00100,
    ST_SAMPLE = 5'b01000,
    ST_DONE   = 5'b10000
  } acs_seq_state_t;

endpackage

/* File: rtl/acs_dac_regs.sv */
// dac input and output register pairs with the load strobe
// assumes load_n_i is already synchronised to core_clk_i
`timescale 1ns/1ps
module acs_dac_regs #(
  parameter int N_DAC = 4
) (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     sys_rst_i,
  // write and load
  input  wire acs_pkg::acs_dac_wr_t     wr_i,
  input  wire logic                     load_n_i,
  // codes
  output logic [N_DAC-1:0][11:0]        code_o
);

  if (N_DAC < 1 || N_DAC > 4) begin : g_bad_n
    $error("N_DAC must be 1 to 4");
  end

  for (genvar g = 0; g < N_DAC; g++)
  begin : g_ch
    logic [11:0] in_r;
    logic [11:0] in_nxt;
    logic [11:0] out_r;
    logic [11:0] out_nxt;

    always_comb
    begin
      in_nxt = in_r;
      if (wr_i.valid && wr_i.ch == 2'(g))
      begin
        in_nxt = wr_i.data;
      end
      // copy on low, and keep following while low
      out_nxt = load_n_i ? out_r : in_r;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        in_r  <= 12'h000;
        out_r <= 12'h000;
      end
      else
      begin
        in_r  <= in_nxt;
        out_r <= out_nxt;
      end
    end

    assign code_o[g] = out_r;
  end

endmodule // acs_dac_regs

/* File: rtl/acs_sequencer.sv */
// serial command front end and conversion sequencer of a multichannel adc
// assumes the spi pins come from another domain and are sampled here;
// the analog front end delivers adc_result_i in step with its strobes
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int NUM_CH       = 16,
  parameter int FIFO_DEPTH   = 32,
  parameter int N_DAC        = 4,
  parameter int AVG_LOG2_MAX = 5,
  parameter int SAMPLE_CYC   = acs_pkg::SAMPLE_CYC,
  parameter int TEMP_CYC     = acs_pkg::TEMP_CYC,
  parameter int WAKE_CYC     = acs_pkg::WAKE_CYC,
  localparam int AW          = $clog2(FIFO_DEPTH)
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // serial link
  input  wire logic                 spi_sclk_i,
  input  wire logic                 spi_cs_n_i,
  input  wire logic                 spi_mosi_i,
  output logic                      spi_miso_o,
  // configuration
  input  wire logic                 clock_mode_select_hi_i,
  input  wire logic                 clock_mode_select_lo_i,
  input  wire logic                 clock_mode_load_i,
  input  wire logic                 bias_keep_on_i,
  input  wire logic                 ext_ref_i,
  input  wire logic                 bipolar_i,
  input  wire logic [2:0]           avg_log2_i,
  input  wire logic [3:0]           scan_repeat_i,
  // analog front end
  input  wire logic [11:0]          adc_result_i,
  output logic [3:0]                adc_channel_o,
  output logic                      adc_temp_o,
  output logic                      adc_sample_o,
  output logic                      analog_on_o,
  output logic                      bias_on_o,
  // status
  output logic                      conv_done_n_o,
  output logic                      busy_o,
  output logic [1:0]                clock_mode_o,
  output logic [AW:0]               fifo_count_o,
  // dac and gpio
  input  wire logic                 dac_load_n_i,
  output logic [N_DAC-1:0][11:0]    dac_code_o,
  output logic [7:0]                gpio_o
);

  if (NUM_CH < 1 || NUM_CH > 16 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0
      || AVG_LOG2_MAX > 5 || SAMPLE_CYC < 1 || TEMP_CYC < 1 || WAKE_CYC < 1
      || SAMPLE_CYC > 65535 || TEMP_CYC > 65535 || WAKE_CYC > 65535) begin : g_bad_cfg
    $error("acs_sequencer parameters out of range");
  end

  localparam logic [15:0] T_SAMPLE = 16'(SAMPLE_CYC - 1);
  localparam logic [15:0] T_TEMP   = 16'(TEMP_CYC - 1);
  localparam logic [15:0] T_WAKE   = 16'(WAKE_CYC - 1);
  localparam logic [3:0]  LAST_CH  = 4'(NUM_CH - 1);
  localparam logic [2:0]  AVG_MAX  = 3'(AVG_LOG2_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [1:0] sclk_s, cs_s, mosi_s, ld_s;
  logic       sclk_q, cs_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sclk_s <= 2'h0;
      cs_s   <= 2'h3;
      mosi_s <= 2'h0;
      ld_s   <= 2'h3;
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], spi_sclk_i};
      cs_s   <= {cs_s[0], spi_cs_n_i};
      mosi_s <= {mosi_s[0], spi_mosi_i};
      ld_s   <= {ld_s[0], dac_load_n_i};
      sclk_q <= sclk_s[1];
      cs_q   <= cs_s[1];
    end
  end

  logic rise, fall, cs_sel, cs_fall, cs_rise;
  assign rise    = sclk_s[1] & ~sclk_q;
  assign fall    = ~sclk_s[1] & sclk_q;
  assign cs_sel  = ~cs_s[1];
  assign cs_fall = ~cs_s[1] & cs_q;
  assign cs_rise = cs_s[1] & ~cs_q;

  ////////////////////////////////////////////////////////////////////////////
  // command receiver
  logic [15:0]          rx_sh_r, rx_sh_nxt, rx_bit;
  logic [4:0]           bit_cnt_r, bit_cnt_nxt, cnt_inc;
  logic [7:0]           gpio_r, gpio_nxt;
  logic                 conv_ev, nop_ev;
  acs_pkg::acs_dac_wr_t dac_wr;
  acs_pkg::acs_conv_cmd_t rx_cmd;

  assign rx_bit = {rx_sh_r[14:0], mosi_s[1]};
  assign cnt_inc = bit_cnt_r + 5'h01;
  assign rx_cmd = acs_pkg::acs_conv_cmd_t'(rx_bit[6:0]);

  always_comb
  begin
    rx_sh_nxt   = rx_sh_r;
    bit_cnt_nxt = bit_cnt_r;
    gpio_nxt    = gpio_r;
    conv_ev     = 1'b0;
    nop_ev      = 1'b0;
    dac_wr      = '0;
    if (cs_rise)
    begin
      bit_cnt_nxt = 5'h00;
    end
    else if (rise && cs_sel)
    begin
      rx_sh_nxt   = rx_bit;
      bit_cnt_nxt = cnt_inc;
      if (cnt_inc == acs_pkg::BYTE_BITS)
      begin
        bit_cnt_nxt = 5'h00;
        if (rx_bit[acs_pkg::CONV_BIT])
          conv_ev = 1'b1;
        else if (rx_bit[7:0] == acs_pkg::NOP_BYTE)
          nop_ev = 1'b1;
        else if (rx_bit[7:6] == acs_pkg::DAC_PREFIX || rx_bit[7:5] == acs_pkg::GPIO_PREFIX)
          bit_cnt_nxt = cnt_inc;
      end
      else if (cnt_inc == acs_pkg::WORD_BITS)
      begin
        bit_cnt_nxt = 5'h00;
        // taken whatever the sequencer is doing
        dac_wr.valid = (rx_bit[15:14] == acs_pkg::DAC_PREFIX);
        dac_wr.ch    = rx_bit[13:12];
        dac_wr.data  = rx_bit[11:0];
        if (rx_bit[15:13] == acs_pkg::GPIO_PREFIX)
          gpio_nxt = rx_bit[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_sh_r   <= 16'h0000;
      bit_cnt_r <= 5'h00;
      gpio_r    <= 8'h00;
    end
    else
    begin
      rx_sh_r   <= rx_sh_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      gpio_r    <= gpio_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock mode
  logic [1:0] mode_r, mode_nxt;
  logic       ext;

  always_comb
  begin
    mode_nxt = clock_mode_load_i ? {clock_mode_select_hi_i, clock_mode_select_lo_i} : mode_r;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mode_r <= acs_pkg::MODE_RST;
    else
      mode_r <= mode_nxt;
  end

  assign ext = (mode_r == acs_pkg::MODE_EXT);

  ////////////////////////////////////////////////////////////////////////////
  // internally timed scan sequencer
  acs_pkg::acs_seq_state_t st_r, st_nxt;
  acs_pkg::acs_conv_cmd_t  cmd_r, cmd_nxt;
  logic [3:0]  ch_r, ch_nxt, rep_r, rep_nxt, rep_m1;
  logic [4:0]  avg_r, avg_nxt, navg_m1;
  logic [16:0] acc_r, acc_nxt, acc_sum, res_ext, avg_sh;
  logic [15:0] tmr_r, tmr_nxt;
  logic [11:0] push_data;
  logic [2:0]  avg_l;
  logic        eoc_n_r, eoc_n_nxt, push, flush, sample, done, last;

  assign avg_l   = (avg_log2_i > AVG_MAX) ? AVG_MAX : avg_log2_i;
  assign navg_m1 = 5'((6'h01 << avg_l) - 6'h01);
  assign rep_m1  = (scan_repeat_i == 4'h0) ? 4'h0 : scan_repeat_i - 4'h1;
  assign res_ext = {{5{bipolar_i & adc_result_i[11]}}, adc_result_i};
  assign acc_sum = acc_r + res_ext;
  assign avg_sh  = bipolar_i ? 17'($signed(acc_sum) >>> avg_l) : acc_sum >> avg_l;
  assign last    = (cmd_r.scan == acs_pkg::SCAN_FROM0)  ? (ch_r == cmd_r.chsel) :
                   (cmd_r.scan == acs_pkg::SCAN_TOLAST) ? (ch_r == LAST_CH) :
                   (cmd_r.scan == acs_pkg::SCAN_REPEAT) ? (rep_r == rep_m1) : 1'b1;

  always_comb
  begin
    st_nxt    = st_r;
    cmd_nxt   = cmd_r;
    ch_nxt    = ch_r;
    rep_nxt   = rep_r;
    avg_nxt   = avg_r;
    acc_nxt   = acc_r;
    tmr_nxt   = (tmr_r != 16'h0000) ? tmr_r - 16'h0001 : tmr_r;
    push      = 1'b0;
    push_data = adc_result_i;
    flush     = 1'b0;
    sample    = 1'b0;
    done      = 1'b0;
    unique case (st_r)
      acs_pkg::ST_IDLE:
        if (conv_ev && !ext)
        begin
          cmd_nxt = rx_cmd;
          ch_nxt  = (rx_cmd.scan == acs_pkg::SCAN_FROM0) ? 4'h0 : rx_cmd.chsel;
          rep_nxt = 4'h0;
          avg_nxt = 5'h00;
          acc_nxt = 17'h00000;
          flush   = 1'b1;
          // wake, then temperature, then samples add up to the scan time
          if (ext_ref_i)
          begin
            st_nxt  = acs_pkg::ST_WAKE;
            tmr_nxt = T_WAKE;
          end
          else if (rx_cmd.temp)
          begin
            st_nxt  = acs_pkg::ST_TEMP;
            tmr_nxt = T_TEMP;
          end
          else
          begin
            st_nxt  = acs_pkg::ST_SAMPLE;
            tmr_nxt = T_SAMPLE;
          end
        end
        else if (conv_ev && !rx_cmd.temp)
          ch_nxt = rx_cmd.chsel;
      acs_pkg::ST_WAKE:
        if (tmr_r == 16'h0000)
        begin
          st_nxt  = cmd_r.temp ? acs_pkg::ST_TEMP : acs_pkg::ST_SAMPLE;
          tmr_nxt = cmd_r.temp ? T_TEMP : T_SAMPLE;
        end
      acs_pkg::ST_TEMP:
        if (tmr_r == 16'h0000)
        begin
          push    = 1'b1;
          st_nxt  = acs_pkg::ST_SAMPLE;
          tmr_nxt = T_SAMPLE;
        end
      acs_pkg::ST_SAMPLE:
        if (tmr_r == 16'h0000)
        begin
          sample  = 1'b1;
          tmr_nxt = T_SAMPLE;
          if (avg_r == navg_m1)
          begin
            push      = 1'b1;
            push_data = avg_sh[11:0];
            acc_nxt   = 17'h00000;
            avg_nxt   = 5'h00;
            if (last)
              st_nxt = acs_pkg::ST_DONE;
            else if (cmd_r.scan == acs_pkg::SCAN_REPEAT)
              rep_nxt = rep_r + 4'h1;
            else
              ch_nxt = ch_r + 4'h1;
          end
          else
          begin
            acc_nxt = acc_sum;
            avg_nxt = avg_r + 5'h01;
          end
        end
      acs_pkg::ST_DONE:
      begin
        st_nxt = acs_pkg::ST_IDLE;
        done   = 1'b1;
      end
      default:
        st_nxt = acs_pkg::ST_IDLE;
    endcase
    // completion beats a chip select fall in the same cycle
    eoc_n_nxt = done ? 1'b0 : (cs_fall ? 1'b1 : eoc_n_r);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r    <= acs_pkg::ST_IDLE;
      cmd_r   <= '0;
      ch_r    <= 4'h0;
      rep_r   <= 4'h0;
      avg_r   <= 5'h00;
      acc_r   <= 17'h00000;
      tmr_r   <= 16'h0000;
      eoc_n_r <= 1'b1;
    end
    else
    begin
      st_r    <= st_nxt;
      cmd_r   <= cmd_nxt;
      ch_r    <= ch_nxt;
      rep_r   <= rep_nxt;
      avg_r   <= avg_nxt;
      acc_r   <= acc_nxt;
      tmr_r   <= tmr_nxt;
      eoc_n_r <= eoc_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result fifo
  logic [11:0] mem_r [FIFO_DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   fcnt_r, fcnt_nxt;
  logic          push_ok, pop, pop_ok;
  logic [11:0]   head;

  assign push_ok = push & (fcnt_r != (AW+1)'(FIFO_DEPTH));
  assign pop_ok  = pop & (fcnt_r != '0);
  assign head    = mem_r[rp_r];

  always_comb
  begin
    wp_nxt   = push_ok ? wp_r + AW'(1) : wp_r;
    rp_nxt   = pop_ok ? rp_r + AW'(1) : rp_r;
    fcnt_nxt = fcnt_r + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    if (flush)
    begin
      wp_nxt   = '0;
      rp_nxt   = '0;
      fcnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wp_r   <= '0;
      rp_r   <= '0;
      fcnt_r <= '0;
    end
    else
    begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (push_ok)
      mem_r[wp_r] <= push_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode 11 nop tracking and serial output
  logic [15:0] out_sh_r, sh_nxt;
  logic [4:0]  out_cnt_r, oc_nxt, nop_r, nop_nxt;
  logic        temp11_r, temp11_nxt, a11_r, a11_nxt;

  always_comb
  begin
    nop_nxt    = nop_r;
    temp11_nxt = temp11_r;
    a11_nxt    = a11_r;
    if (conv_ev && ext)
    begin
      nop_nxt    = 5'h00;
      temp11_nxt = rx_cmd.temp;
      a11_nxt    = 1'b1;
    end
    else if (nop_ev && ext && a11_r)
    begin
      nop_nxt = (nop_r == 5'h1F) ? nop_r : nop_r + 5'h01;
      if (!temp11_r && nop_nxt == acs_pkg::NOP_PD_CNT)
        a11_nxt = 1'b0;
      if (temp11_r && nop_nxt == acs_pkg::TEMP_END_CNT)
        a11_nxt = 1'b0;
    end
  end

  always_comb
  begin
    sh_nxt = out_sh_r;
    oc_nxt = out_cnt_r;
    pop    = 1'b0;
    if (conv_ev && ext && !rx_cmd.temp)
    begin
      sh_nxt = {acs_pkg::LEAD_ZEROS, adc_result_i};
      oc_nxt = acs_pkg::WORD_BITS;
    end
    else if (nop_ev && ext && temp11_r && nop_nxt == acs_pkg::TEMP_LOAD_CNT)
    begin
      sh_nxt = {acs_pkg::LEAD_ZEROS, adc_result_i};
      oc_nxt = acs_pkg::WORD_BITS;
    end
    else if (ext)
    begin
      // keeps shifting across a short chip select pulse
      if (rise && out_cnt_r != 5'h00)
      begin
        sh_nxt = {out_sh_r[14:0], 1'b0};
        oc_nxt = out_cnt_r - 5'h01;
      end
    end
    else if (cs_fall && out_cnt_r == 5'h00 && fcnt_r != '0 && st_r == acs_pkg::ST_IDLE)
    begin
      sh_nxt = {acs_pkg::LEAD_ZEROS, head};
      oc_nxt = acs_pkg::WORD_BITS;
    end
    else if (fall && cs_sel && out_cnt_r != 5'h00)
    begin
      sh_nxt = {out_sh_r[14:0], 1'b0};
      oc_nxt = out_cnt_r - 5'h01;
      pop    = (out_cnt_r == 5'h01);
    end
    else if (cs_rise && out_cnt_r == acs_pkg::WORD_BITS)
      oc_nxt = 5'h00;
    else if (cs_rise && out_cnt_r > acs_pkg::BYTE_BITS)
    begin
      sh_nxt = {head[7:0], 8'h00};
      oc_nxt = acs_pkg::BYTE_BITS;
    end
    else if (cs_rise && out_cnt_r != 5'h00 && out_cnt_r < acs_pkg::BYTE_BITS)
    begin
      pop    = 1'b1;
      oc_nxt = 5'h00;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      out_sh_r  <= 16'h0000;
      out_cnt_r <= 5'h00;
      nop_r     <= 5'h00;
      temp11_r  <= 1'b0;
      a11_r     <= 1'b0;
    end
    else
    begin
      out_sh_r  <= sh_nxt;
      out_cnt_r <= oc_nxt;
      nop_r     <= nop_nxt;
      temp11_r  <= temp11_nxt;
      a11_r     <= a11_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac registers
  acs_dac_regs #(
    .N_DAC      (N_DAC)
  ) u_dac (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_i       (dac_wr),
    .load_n_i   (ld_s[1]),
    .code_o     (dac_code_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign spi_miso_o    = out_sh_r[15];
  assign adc_channel_o = ch_r;
  assign adc_temp_o    = (st_r == acs_pkg::ST_TEMP) | (ext & temp11_r & a11_r);
  assign adc_sample_o  = sample | (conv_ev & ext & ~rx_cmd.temp);
  assign analog_on_o   = (st_r != acs_pkg::ST_IDLE) | a11_r;
  assign bias_on_o     = analog_on_o | bias_keep_on_i;
  assign conv_done_n_o = eoc_n_r;
  assign busy_o        = (st_r != acs_pkg::ST_IDLE);
  assign clock_mode_o  = mode_r;
  assign fifo_count_o  = fcnt_r;
  assign gpio_o        = gpio_r;

endmodule // acs_sequencer

/* File: sim/acs_sequencer_props.sv */
// port assertions of the conversion sequencer
// assumes one core clock and an async active-high reset
`timescale 1ns/1ps
module acs_sequencer_props #(
  parameter int  FIFO_DEPTH = 32,
  localparam int AW         = $clog2(FIFO_DEPTH)
) (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  // link and status
  input wire logic        spi_sclk_i,
  input wire logic        spi_cs_n_i,
  input wire logic        spi_miso_o,
  input wire logic        bias_keep_on_i,
  input wire logic        adc_sample_o,
  input wire logic        bias_on_o,
  input wire logic        conv_done_n_o,
  input wire logic        busy_o,
  input wire logic [1:0]  clock_mode_o,
  input wire logic [AW:0] fifo_count_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] rise_r;
  logic [3:0] rise_nxt;
  logic       sclk_r;
  // cycles since serial clock rose
  always_comb
  begin
    rise_nxt = (rise_r == 4'hF) ? 4'hF : rise_r + 4'h1;
    if (spi_sclk_i && !sclk_r)
      rise_nxt = 4'h0;
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      {sclk_r, rise_r} <= 5'h0F;
    else
      {sclk_r, rise_r} <= {spi_sclk_i, rise_nxt};
  end
  sequence s_cs_idle;
    spi_cs_n_i [*5];
  endsequence
  AST_MODE_RST: assert property ($fell(sys_rst_i) |-> clock_mode_o == acs_pkg::MODE_RST)
    else $error("mode not default");
  AST_SAMPLE_BUSY: assert property (adc_sample_o && clock_mode_o == acs_pkg::MODE_RST |-> busy_o)
    else $error("sample outside scan");
  AST_DONE_SET: assert property ($fell(conv_done_n_o) |-> $past(busy_o) && !busy_o)
    else $error("done without scan end");
  AST_DONE_HOLD: assert property (s_cs_idle ##0 !conv_done_n_o |=> !conv_done_n_o)
    else $error("done released early");
  AST_DONE_REL: assert property ($fell(spi_cs_n_i) && !conv_done_n_o && !busy_o
    |-> ##[1:6] conv_done_n_o) else $error("done not released");
  AST_FIFO_OFF: assert property (clock_mode_o == acs_pkg::MODE_EXT
    |=> fifo_count_o <= $past(fifo_count_o)) else $error("fifo grew");
  AST_BIAS: assert property (bias_keep_on_i |-> bias_on_o)
    else $error("bias off");
  AST_M11_EDGE: assert property (clock_mode_o == acs_pkg::MODE_EXT && rise_r != 4'hF
    && $changed(spi_miso_o) |-> rise_r inside {[1:3]}) else $error("miso on falling edge");
endmodule // acs_sequencer_props

bind acs_sequencer acs_sequencer_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .core_clk_i, .sys_rst_i, .spi_sclk_i, .spi_cs_n_i, .spi_miso_o, .bias_keep_on_i,
  .adc_sample_o, .bias_on_o, .conv_done_n_o, .busy_o, .clock_mode_o, .fifo_count_o
);

/* File: sim/acs_host.sv */
// serial host model: chip select, serial clock, data
// assumes the core clock; the bench calls its tasks
`timescale 1ns/1ps
module acs_host (
  // clock
  input  wire logic clk_i,
  // serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial {sclk_o, cs_n_o, mosi_o} = 3'h2;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // n bits msb first; miso taken before its changing edge
  task automatic xfer(input logic [15:0] tx, input int n, input bit on_rise,
                      output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      mosi_o = tx[15-i];
      tick(4);
      if (on_rise) rx = {rx[14:0], miso_i};
      sclk_o = 1'b1;
      tick(4);
      if (!on_rise) rx = {rx[14:0], miso_i};
      sclk_o = 1'b0;
    end
    tick(4);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    tick(8); // short high gap
  endtask
endmodule // acs_host

/* File: sim/acs_sequencer_test.sv */
// self-checking bench of the conversion sequencer
// assumes the host model and the bound port checker
`timescale 1ns/1ps
module acs_sequencer_test;
  logic             core_clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic             spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o;
  logic             clock_mode_select_hi_i = 1'b1;
  logic             clock_mode_select_lo_i = 1'b0;
  logic             clock_mode_load_i = 1'b0;
  logic             bias_keep_on_i = 1'b0;
  logic             dac_load_n_i = 1'b1;
  logic             ext_ref_i = 1'b1;
  logic             bipolar_i = 1'b0;
  logic [2:0]       avg_log2_i = 3'h1;
  logic [3:0]       scan_repeat_i = 4'h1;
  logic             alt = 1'b1;
  logic [7:0]       gpio_o;
  logic [11:0]      adc_result_i;
  logic [3:0]       adc_channel_o;
  logic             adc_temp_o, adc_sample_o, analog_on_o, bias_on_o, conv_done_n_o, busy_o;
  logic [1:0]       clock_mode_o;
  logic [5:0]       fifo_count_o;
  logic [3:0][11:0] dac_code_o;
  logic [15:0]      rx, rx2;
  int               n_errors = 0, compares = 0, n_busy = 0;
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (busy_o === 1'b1) n_busy++;
  // bipolar runs alternate 800 and 000 so the signed average differs from the plain one
  always @(posedge core_clk_i) if (adc_sample_o === 1'b1) alt <= ~alt;
  assign adc_result_i = adc_temp_o ? 12'h7F1 : (bipolar_i ? {alt, 11'h000} : 12'h123);
  acs_host host (.clk_i(core_clk_i), .sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i),
                 .mosi_o(spi_mosi_i), .miso_i(spi_miso_o));
  acs_sequencer #(.SAMPLE_CYC(300), .TEMP_CYC(4), .WAKE_CYC(4)) uut (
    .core_clk_i, .sys_rst_i, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o,
    .clock_mode_select_hi_i, .clock_mode_select_lo_i, .clock_mode_load_i,
    .bias_keep_on_i, .ext_ref_i, .bipolar_i, .avg_log2_i,
    .scan_repeat_i, .adc_result_i, .adc_channel_o, .adc_temp_o, .adc_sample_o,
    .analog_on_o, .bias_on_o, .conv_done_n_o, .busy_o, .clock_mode_o, .fifo_count_o,
    .dac_load_n_i, .dac_code_o, .gpio_o
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    host.tick(10);
    sys_rst_i = 1'b0;
    host.tick(2);
    check(16'({clock_mode_o, conv_done_n_o}), 16'h0005);
    host.xfer(16'h9700, 5, 0, rx);
    check(16'(busy_o), 16'h0000);
    host.xfer(16'h9700, 8, 0, rx); // temp and channel 2, single
    check(16'(busy_o), 16'h0001);
    host.xfer(16'h5ABC, 16, 0, rx);
    check(16'(dac_code_o[1]), 16'h0000);
    dac_load_n_i = 1'b0;
    host.tick(6);
    check(16'(dac_code_o[1]), 16'h0ABC);
    host.xfer(16'h5456, 16, 0, rx);
    host.tick(6);
    check(16'(dac_code_o[1]), 16'h0456);
    host.xfer(16'h20A5, 16, 0, rx);
    check(16'(gpio_o), 16'h00A5);
    for (int i = 0; i < 800 && conv_done_n_o !== 1'b0; i++) host.tick(1);
    check(16'(n_busy >= 606 && n_busy <= 612), 16'h0001);
    host.tick(20);
    check(16'({fifo_count_o, analog_on_o, conv_done_n_o}), 16'h0008);
    host.xfer(16'h0000, 16, 0, rx);
    check(rx, 16'h07F1);
    check(16'(conv_done_n_o), 16'h0001);
    host.xfer(16'h0000, 16, 0, rx);
    check(rx, 16'h0123);
    clock_mode_select_lo_i = 1'b1;
    clock_mode_load_i = 1'b1;
    host.tick(1);
    clock_mode_load_i = 1'b0;
    bias_keep_on_i = 1'b1;
    host.tick(3);
    host.xfer(16'h8800, 8, 1, rx); // channel 1, 16 clocks follow
    check(16'({clock_mode_o, adc_channel_o, analog_on_o}), 16'h0063);
    host.xfer(16'h0000, 8, 1, rx); // first of two spacer bytes
    host.xfer(16'h0000, 8, 1, rx2);
    check({rx[7:0], rx2[7:0]}, 16'h0123);
    check(16'({fifo_count_o, analog_on_o, bias_on_o}), 16'h0001);
    host.xfer(16'hF900, 8, 1, rx);
    check(16'({adc_channel_o, adc_temp_o}), 16'h0003);
    host.tick(900); // reference wake, chip select high
    for (int i = 0; i < 24; i++)
    begin
      host.xfer(16'h0000, 8, 1, rx2); // separately framed spacers
      if (i == 22) rx = rx2;
    end
    check({rx[7:0], rx2[7:0]}, 16'h07F1);
    check(16'(analog_on_o), 16'h0000);
    clock_mode_select_lo_i = 1'b0;
    clock_mode_load_i = 1'b1;
    ext_ref_i = 1'b0;
    bipolar_i = 1'b1;
    scan_repeat_i = 4'h2;
    host.tick(1);
    clock_mode_load_i = 1'b0;
    alt = 1'b1;
    n_busy = 0;
    host.xfer(16'h9C00, 8, 0, rx); // channel 3, repeated scan, no wake
    for (int i = 0; i < 1400 && conv_done_n_o !== 1'b0; i++) host.tick(1);
    check(16'(n_busy), 16'h04B1);
    check(16'({clock_mode_o, fifo_count_o, adc_channel_o, conv_done_n_o}), 16'h1046);
    host.xfer(16'h0000, 16, 0, rx);
    check(rx, 16'h0C00);
    host.xfer(16'h0000, 16, 0, rx2);
    check(rx2, 16'h0C00);
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    test_done;
  end
endmodule // acs_sequencer_test
